// ### src/mic_pkg.sv
// Shared constants and types of the interrupt controller
package mic_pkg;
    // ------------------------------------------------------------
    // Sources
    // ------------------------------------------------------------
    localparam int NUM_SRC = 7;
    localparam int SRC_PORT_A = 0;
    localparam int SRC_PORT_B = 1;
    localparam int SRC_WIDE_TMR = 2;
    localparam int SRC_CMP = 3;
    localparam int SRC_TMR2 = 4;
    localparam int SRC_TMR3 = 5;
    localparam int SRC_PWM0 = 6;

    // ------------------------------------------------------------
    // Register map (byte addresses, 8-bit data)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS = 8'h00;
    localparam logic [7:0] ADDR_ENABLE = 8'h01;
    localparam logic [7:0] ADDR_EDGE_A = 8'h02;
    localparam logic [7:0] ADDR_EDGE_B = 8'h03;
    localparam logic [7:0] ADDR_SP = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h05;
    localparam logic [6:0] FLAGS_RST = 7'h00;
    localparam logic [6:0] ENABLE_RST = 7'h00;
    localparam logic [7:0] EDGE_A_RST = 8'h00;
    localparam logic [5:0] EDGE_B_RST = 6'h00;
    localparam logic [7:0] SP_RST = 8'h00;
    localparam logic [7:0] EDGE_A_MASK = 8'hdf;
    localparam logic [7:0] SP_MASK = 8'hfe;
    localparam int WIDE_TMR_EDGE_BIT = 4;

    // ------------------------------------------------------------
    // Edge modes, stack and vector
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [7:0] SP_ONE = 8'h01;
    localparam logic [7:0] SP_STEP = 8'h02;
    localparam logic [15:0] VECTOR_ADDR = 16'h0010;

    typedef enum logic [1:0] {
        OP_PUSH_PC,
        OP_PUSH_AF,
        OP_POP_PC,
        OP_POP_AF
    } mic_stk_op_e;
endpackage

// ### src/mic_stk_if.sv
// Link between the controller core and its stack engine
`timescale 1ns/1ps
`default_nettype none
interface mic_stk_if;
    logic start;
    mic_pkg::mic_stk_op_e op;
    logic [15:0] wdata;
    logic [7:0] sp;
    logic done;
    logic [15:0] rdata;
    logic [7:0] sp_new;
    logic mem_we;
    logic mem_re;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    modport ctrl (output start, op, wdata, sp, mem_rdata,
        input done, rdata, sp_new, mem_we, mem_re, mem_addr, mem_wdata);
    modport eng (input start, op, wdata, sp, mem_rdata,
        output done, rdata, sp_new, mem_we, mem_re, mem_addr, mem_wdata);
endinterface
`default_nettype wire

// ### src/mic_edge.sv
// Source synchroniser and selectable edge detector
`timescale 1ns/1ps
`default_nettype none
module mic_edge (
    input wire logic clk,
    input wire logic rstn,
    input wire logic src,
    input wire logic [1:0] mode,
    output logic evt
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic last;
        logic evt;
    } mic_edge_s;

    mic_edge_s q_reg;
    mic_edge_s q_next;
    logic rise;
    logic fall;

    // Two-stage sync, then edge pick by mode
    always_comb begin
        q_next = q_reg;
        q_next.sync1 = src;
        q_next.sync2 = q_reg.sync1;
        q_next.last = q_reg.sync2;
        rise = q_reg.sync2 & ~q_reg.last;
        fall = ~q_reg.sync2 & q_reg.last;
        if (mode == mic_pkg::EDGE_RISE) begin
            q_next.evt = rise;
        end else if (mode == mic_pkg::EDGE_FALL) begin
            q_next.evt = fall;
        end else begin
            q_next.evt = rise | fall;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign evt = q_reg.evt;
endmodule
`default_nettype wire

// ### src/mic_stack.sv
// Stack engine: two-byte pushes and pops in data memory
`timescale 1ns/1ps
`default_nettype none
module mic_stack (
    input wire logic clk,
    input wire logic rstn,
    mic_stk_if.eng stk
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_WR_HI, ST_FIN, ST_RD_LO, ST_RD_HI, ST_RD_END
    } mic_eng_state_e;

    typedef struct packed {
        mic_eng_state_e state;
        logic [15:0] data;
        logic [7:0] sp;
        logic we;
        logic re;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic done;
        logic [7:0] sp_new;
    } mic_eng_s;

    mic_eng_s q_reg;
    mic_eng_s q_next;

    // Low byte at sp, high byte at sp+1; pops read back sp-2, sp-1
    always_comb begin
        q_next = q_reg;
        q_next.done = 1'b0;
        unique case (q_reg.state)
            ST_IDLE: begin
                if (stk.start) begin
                    q_next.sp = stk.sp;
                    q_next.data = stk.wdata;
                    if (stk.op == mic_pkg::OP_PUSH_PC ||
                        stk.op == mic_pkg::OP_PUSH_AF) begin
                        q_next.we = 1'b1;
                        q_next.addr = stk.sp;
                        q_next.wdata = stk.wdata[7:0];
                        q_next.state = ST_WR_HI;
                    end else begin
                        q_next.re = 1'b1;
                        q_next.addr = stk.sp - mic_pkg::SP_STEP;
                        q_next.state = ST_RD_LO;
                    end
                end
            end
            ST_WR_HI: begin
                q_next.addr = q_reg.sp + mic_pkg::SP_ONE;
                q_next.wdata = q_reg.data[15:8];
                q_next.state = ST_FIN;
            end
            ST_FIN: begin
                q_next.we = 1'b0;
                q_next.done = 1'b1;
                q_next.sp_new = q_reg.sp + mic_pkg::SP_STEP;
                q_next.state = ST_IDLE;
            end
            ST_RD_LO: begin
                q_next.addr = q_reg.sp - mic_pkg::SP_ONE;
                q_next.state = ST_RD_HI;
            end
            ST_RD_HI: begin
                q_next.re = 1'b0;
                q_next.data[7:0] = stk.mem_rdata;
                q_next.state = ST_RD_END;
            end
            ST_RD_END: begin
                q_next.data[15:8] = stk.mem_rdata;
                q_next.done = 1'b1;
                q_next.sp_new = q_reg.sp - mic_pkg::SP_STEP;
                q_next.state = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign stk.done = q_reg.done;
    assign stk.rdata = q_reg.data;
    assign stk.sp_new = q_reg.sp_new;
    assign stk.mem_we = q_reg.we;
    assign stk.mem_re = q_reg.re;
    assign stk.mem_addr = q_reg.addr;
    assign stk.mem_wdata = q_reg.wdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Latched pointer stays put for the whole operation
    sequence seq_push_pair;
        (q_reg.we && q_reg.addr == q_reg.sp) ##1
        (q_reg.we && q_reg.addr == q_reg.sp + mic_pkg::SP_ONE) ##1
        !q_reg.we;
    endsequence

    sequence seq_pop_pair;
        (q_reg.re && q_reg.addr == q_reg.sp - mic_pkg::SP_STEP) ##1
        (q_reg.re && q_reg.addr == q_reg.sp - mic_pkg::SP_ONE) ##1
        !q_reg.re;
    endsequence

    chk_push_two_bytes: assert property (
        $rose(q_reg.we) |-> seq_push_pair)
        else $error("push does not write sp then sp+1");

    chk_pop_two_bytes: assert property (
        $rose(q_reg.re) |-> seq_pop_pair)
        else $error("pop does not read sp-2 then sp-1");
endmodule
`default_nettype wire

// ### src/mic_ctrl.sv
// Interrupt controller core: flags, enables, stack pointer, sequencing
`timescale 1ns/1ps
`default_nettype none
module mic_ctrl (
    input wire logic CORE_CLK,
    input wire logic RSTN,
    input wire logic PORT_A_PIN0_SOURCE,
    input wire logic PORT_B_PIN0_SOURCE,
    input wire logic WIDE_TIMER_SOURCE,
    input wire logic COMPARATOR_SOURCE,
    input wire logic SECOND_TIMER_SOURCE,
    input wire logic THIRD_TIMER_SOURCE,
    input wire logic PWM_GEN_ZERO_SOURCE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic CPU_BOUNDARY,
    input wire logic [15:0] CPU_PC,
    input wire logic CPU_ENGINT,
    input wire logic CPU_DISGINT,
    input wire logic CPU_RETI,
    input wire logic CPU_PUSHAF,
    input wire logic CPU_POPAF,
    input wire logic [7:0] CPU_ACC,
    input wire logic [7:0] CPU_FLAGS,
    output logic BUSY,
    output logic GIE,
    output logic JUMP_LOAD,
    output logic [15:0] JUMP_PC,
    output logic AF_LOAD,
    output logic [7:0] AF_ACC,
    output logic [7:0] AF_FLAGS,
    output logic MEM_WE,
    output logic MEM_RE,
    output logic [7:0] MEM_ADDR,
    output logic [7:0] MEM_WDATA,
    input wire logic [7:0] MEM_RDATA
);
    localparam int N = mic_pkg::NUM_SRC;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [N-1:0] flags;
        logic [N-1:0] enable;
        logic [7:0] edge_a;
        logic [5:0] edge_b;
        logic [7:0] sp;
        logic gie;
        logic busy;
        mic_pkg::mic_stk_op_e op;
        logic start;
        logic [15:0] start_data;
        logic [7:0] rdata;
        logic jump_load;
        logic [15:0] jump_pc;
        logic af_load;
        logic [7:0] af_acc;
        logic [7:0] af_flags;
    } mic_ctrl_s;

    mic_ctrl_s q_reg;
    mic_ctrl_s q_next;
    mic_stk_if stk ();

    logic [N-1:0] src_pins;
    logic [N-1:0] evt;
    logic [1:0] mode [N];
    logic [N-1:0] keep_mask;
    logic pending;
    logic take;
    logic accept_cmd;

    // ------------------------------------------------------------
    // Source capture
    // ------------------------------------------------------------
    // Pin order fixes the flag bit of each source
    assign src_pins[mic_pkg::SRC_PORT_A] = PORT_A_PIN0_SOURCE;
    assign src_pins[mic_pkg::SRC_PORT_B] = PORT_B_PIN0_SOURCE;
    assign src_pins[mic_pkg::SRC_WIDE_TMR] = WIDE_TIMER_SOURCE;
    assign src_pins[mic_pkg::SRC_CMP] = COMPARATOR_SOURCE;
    assign src_pins[mic_pkg::SRC_TMR2] = SECOND_TIMER_SOURCE;
    assign src_pins[mic_pkg::SRC_TMR3] = THIRD_TIMER_SOURCE;
    assign src_pins[mic_pkg::SRC_PWM0] = PWM_GEN_ZERO_SOURCE;

    // Edge mode per source from the two edge-select registers
    always_comb begin
        mode[mic_pkg::SRC_PORT_A] = q_reg.edge_a[1:0];
        mode[mic_pkg::SRC_PORT_B] = q_reg.edge_a[3:2];
        mode[mic_pkg::SRC_WIDE_TMR] =
            q_reg.edge_a[mic_pkg::WIDE_TMR_EDGE_BIT] ?
            mic_pkg::EDGE_FALL : mic_pkg::EDGE_RISE;
        mode[mic_pkg::SRC_CMP] = q_reg.edge_a[7:6];
        mode[mic_pkg::SRC_TMR2] = q_reg.edge_b[1:0];
        mode[mic_pkg::SRC_TMR3] = q_reg.edge_b[3:2];
        mode[mic_pkg::SRC_PWM0] = q_reg.edge_b[5:4];
    end

    // One synchroniser and edge detector per source
    for (genvar i = 0; i < N; i++) begin : g_src
        mic_edge u_edge (
            .clk(CORE_CLK),
            .rstn(RSTN),
            .src(src_pins[i]),
            .mode(mode[i]),
            .evt(evt[i])
        );
    end

    // ------------------------------------------------------------
    // Stack engine
    // ------------------------------------------------------------
    mic_stack u_stack (
        .clk(CORE_CLK),
        .rstn(RSTN),
        .stk(stk)
    );

    assign stk.start = q_reg.start;
    assign stk.op = q_reg.op;
    assign stk.wdata = q_reg.start_data;
    assign stk.sp = q_reg.sp;
    assign stk.mem_rdata = MEM_RDATA;

    // ------------------------------------------------------------
    // Request decision
    // ------------------------------------------------------------
    // Flag, enable and global enable must all agree
    assign pending = q_reg.gie && |(q_reg.flags & q_reg.enable);
    assign take = !q_reg.busy && CPU_BOUNDARY && pending;
    assign accept_cmd = !q_reg.busy && !take;

    // Written zeros clear flags; ones leave them alone
    assign keep_mask = (REG_WR && REG_ADDR == mic_pkg::ADDR_FLAGS) ?
        REG_WDATA[N-1:0] : '1;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        q_next = q_reg;
        q_next.start = 1'b0;
        q_next.jump_load = 1'b0;
        q_next.af_load = 1'b0;
        q_next.rdata = 8'h00;

        // New events win over a clear in the same cycle
        q_next.flags = (q_reg.flags & keep_mask) | evt;

        // Register writes
        if (REG_WR) begin
            unique case (REG_ADDR)
                mic_pkg::ADDR_ENABLE: q_next.enable = REG_WDATA[N-1:0];
                mic_pkg::ADDR_EDGE_A:
                    q_next.edge_a = REG_WDATA & mic_pkg::EDGE_A_MASK;
                mic_pkg::ADDR_EDGE_B: q_next.edge_b = REG_WDATA[5:0];
                mic_pkg::ADDR_SP:
                    q_next.sp = REG_WDATA & mic_pkg::SP_MASK;
                default: ;
            endcase
        end

        // Register reads, data valid in the next cycle only
        if (REG_RD) begin
            unique case (REG_ADDR)
                mic_pkg::ADDR_FLAGS: q_next.rdata = {1'b0, q_reg.flags};
                mic_pkg::ADDR_ENABLE: q_next.rdata = {1'b0, q_reg.enable};
                mic_pkg::ADDR_EDGE_A: q_next.rdata = q_reg.edge_a;
                mic_pkg::ADDR_EDGE_B: q_next.rdata = {2'b00, q_reg.edge_b};
                mic_pkg::ADDR_SP: q_next.rdata = q_reg.sp;
                mic_pkg::ADDR_STATUS:
                    q_next.rdata = {6'h00, q_reg.busy, q_reg.gie};
                default: q_next.rdata = 8'h00;
            endcase
        end

        // Global enable instructions
        if (CPU_ENGINT) begin
            q_next.gie = 1'b1;
        end
        if (CPU_DISGINT) begin
            q_next.gie = 1'b0;
        end

        // Entry or stack instruction starts the engine
        if (take) begin
            q_next.gie = 1'b0;
            q_next.busy = 1'b1;
            q_next.start = 1'b1;
            q_next.op = mic_pkg::OP_PUSH_PC;
            q_next.start_data = CPU_PC;
        end else if (accept_cmd && CPU_RETI) begin
            q_next.busy = 1'b1;
            q_next.start = 1'b1;
            q_next.op = mic_pkg::OP_POP_PC;
        end else if (accept_cmd && CPU_PUSHAF) begin
            q_next.busy = 1'b1;
            q_next.start = 1'b1;
            q_next.op = mic_pkg::OP_PUSH_AF;
            q_next.start_data = {CPU_FLAGS, CPU_ACC};
        end else if (accept_cmd && CPU_POPAF) begin
            q_next.busy = 1'b1;
            q_next.start = 1'b1;
            q_next.op = mic_pkg::OP_POP_AF;
        end

        // Completion: pointer update beats a software write
        if (stk.done) begin
            q_next.busy = 1'b0;
            q_next.sp = stk.sp_new;
            unique case (q_reg.op)
                mic_pkg::OP_PUSH_PC: begin
                    q_next.jump_load = 1'b1;
                    q_next.jump_pc = mic_pkg::VECTOR_ADDR;
                end
                mic_pkg::OP_POP_PC: begin
                    q_next.jump_load = 1'b1;
                    q_next.jump_pc = stk.rdata;
                    q_next.gie = 1'b1;
                end
                mic_pkg::OP_POP_AF: begin
                    q_next.af_load = 1'b1;
                    q_next.af_acc = stk.rdata[7:0];
                    q_next.af_flags = stk.rdata[15:8];
                end
                mic_pkg::OP_PUSH_AF: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            q_reg <= '0;
            q_reg.flags <= mic_pkg::FLAGS_RST;
            q_reg.enable <= mic_pkg::ENABLE_RST;
            q_reg.edge_a <= mic_pkg::EDGE_A_RST;
            q_reg.edge_b <= mic_pkg::EDGE_B_RST;
            q_reg.sp <= mic_pkg::SP_RST;
        end else begin
            q_reg <= q_next;
        end
    end

    // Outputs straight from state
    assign REG_RDATA = q_reg.rdata;
    assign BUSY = q_reg.busy;
    assign GIE = q_reg.gie;
    assign JUMP_LOAD = q_reg.jump_load;
    assign JUMP_PC = q_reg.jump_pc;
    assign AF_LOAD = q_reg.af_load;
    assign AF_ACC = q_reg.af_acc;
    assign AF_FLAGS = q_reg.af_flags;
    assign MEM_WE = stk.mem_we;
    assign MEM_RE = stk.mem_re;
    assign MEM_ADDR = stk.mem_addr;
    assign MEM_WDATA = stk.mem_wdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    sequence seq_vector_jump;
        JUMP_LOAD && JUMP_PC == mic_pkg::VECTOR_ADDR;
    endsequence

    sequence seq_return_jump;
        JUMP_LOAD && GIE && !BUSY;
    endsequence

    chk_entry_clears_gie: assert property (
        take && !CPU_ENGINT |=> !GIE [*4])
        else $error("global enable not held low after entry");

    chk_entry_vector: assert property (
        take |-> ##5 seq_vector_jump)
        else $error("vector jump not five cycles after entry");

    chk_entry_sp_step: assert property (
        take |-> ##5 (q_reg.sp == $past(q_reg.sp, 5) + mic_pkg::SP_STEP))
        else $error("stack pointer not raised by two on entry");

    chk_reti_return: assert property (
        accept_cmd && CPU_RETI |-> ##6 seq_return_jump)
        else $error("return did not jump with global enable set");

    chk_reti_sp_step: assert property (
        accept_cmd && CPU_RETI |->
        ##6 (q_reg.sp == $past(q_reg.sp, 6) - mic_pkg::SP_STEP))
        else $error("stack pointer not lowered by two on return");

    chk_event_sets_flag: assert property (
        evt != '0 |=> (q_reg.flags & $past(evt)) == $past(evt))
        else $error("source event lost its flag");

    chk_flag_only_hw: assert property (
        ((q_reg.flags & ~$past(q_reg.flags)) & ~$past(evt)) == '0)
        else $error("flag set without a source event");

    chk_no_entry_idle: assert property (
        CPU_BOUNDARY && !q_reg.busy && !pending && !CPU_RETI &&
        !CPU_PUSHAF && !CPU_POPAF |=> !BUSY)
        else $error("entry taken without an enabled pending flag");

    chk_sp_even: assert property (
        !q_reg.sp[0])
        else $error("stack pointer bit 0 set");

    chk_popaf_load: assert property (
        accept_cmd && CPU_POPAF && !CPU_RETI && !CPU_PUSHAF |->
        ##6 AF_LOAD)
        else $error("pop of accumulator and flags did not load");
endmodule
`default_nettype wire

// ### sim/mic_mem_model.sv
// Data memory model behind the stack port of the controller
`timescale 1ns/1ps
`default_nettype none
module mic_mem_model (
    input wire logic clk,
    input wire logic we,
    input wire logic re,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] m [256];
    initial rdata = 8'h00;
    // Byte store and one-cycle read; stale data inverted
    always @(posedge clk) begin
        if (we) begin
            m[addr] <= wdata;
        end
        rdata <= re ? m[addr] : ~rdata;
    end
endmodule
`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [6:0] src = 7'h00;
    logic [7:0] addr = 8'h00;
    logic [7:0] wd = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] cmd = 6'h00;
    logic [15:0] pc = 16'h1234;
    logic [7:0] acc = 8'h5a;
    logic [7:0] fl = 8'ha5;
    logic busy, gie, jl, afl, we, re;
    logic [15:0] jpc;
    logic [7:0] rdata, aa, af, maddr, mwd, mrd;
    int miscompares = 0;
    int checks = 0;

    always #5 clk = ~clk;

    mic_ctrl uut (.CORE_CLK(clk), .RSTN(rstn),
        .PORT_A_PIN0_SOURCE(src[0]), .PORT_B_PIN0_SOURCE(src[1]),
        .WIDE_TIMER_SOURCE(src[2]), .COMPARATOR_SOURCE(src[3]),
        .SECOND_TIMER_SOURCE(src[4]), .THIRD_TIMER_SOURCE(src[5]),
        .PWM_GEN_ZERO_SOURCE(src[6]), .REG_ADDR(addr), .REG_WDATA(wd),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .CPU_BOUNDARY(cmd[5]), .CPU_PC(pc), .CPU_ENGINT(cmd[4]),
        .CPU_DISGINT(cmd[3]), .CPU_RETI(cmd[2]), .CPU_PUSHAF(cmd[1]),
        .CPU_POPAF(cmd[0]), .CPU_ACC(acc), .CPU_FLAGS(fl), .BUSY(busy),
        .GIE(gie), .JUMP_LOAD(jl), .JUMP_PC(jpc), .AF_LOAD(afl),
        .AF_ACC(aa), .AF_FLAGS(af), .MEM_WE(we), .MEM_RE(re),
        .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_RDATA(mrd));
    mic_mem_model mem (.clk(clk), .we(we), .re(re), .addr(maddr),
        .wdata(mwd), .rdata(mrd));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk({8'h00, rdata}, {8'h00, e});
    endtask
    // One-cycle CPU command pulse
    task automatic op(input logic [5:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 6'h00;
    endtask
    // Bounded wait for a jump or restore pulse
    task automatic wt(input logic sel, input int cyc);
        int n;
        n = 0;
        while ((sel ? afl : jl) !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(16'(n), 16'(cyc));
    endtask
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        #50us;
        miscompares++;
        wrap_up;
    end

    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rreg(8'h00, 8'h00);
        rreg(8'h05, 8'h00);
        rreg(8'h07, 8'h00);
        wreg(8'h04, 8'h21);
        rreg(8'h04, 8'h20);
        // Each source: rising edge, then falling edge
        for (int i = 0; i < 7; i++) begin
            @(posedge clk);
            src[i] <= 1'b1;
            repeat (6) @(posedge clk);
            rreg(8'h00, 8'h01 << i);
            wreg(8'h00, 8'h00);
            src[i] <= 1'b0;
            repeat (6) @(posedge clk);
            rreg(8'h00, i == 2 ? 8'h00 : 8'h01 << i);
            wreg(8'h00, 8'h00);
        end
        // Single-edge modes: wide timer fall, second_timer_source rise, PWM fall
        wreg(8'h02, 8'hff);
        rreg(8'h02, 8'hdf);
        wreg(8'h03, 8'he1);
        rreg(8'h03, 8'h21);
        src <= 7'h54;
        repeat (6) @(posedge clk);
        rreg(8'h00, 8'h10);
        @(posedge clk);
        src <= 7'h00;
        repeat (6) @(posedge clk);
        rreg(8'h00, 8'h54);
        wreg(8'h00, 8'h00);
        wreg(8'h02, 8'h00);
        op(6'h10);
        @(negedge clk);
        chk({15'h0000, gie}, 16'h0001);
        @(posedge clk);
        src[2] <= 1'b1;
        repeat (6) @(posedge clk);
        op(6'h20);
        repeat (3) @(negedge clk);
        chk({15'h0000, busy}, 16'h0000);
        wreg(8'h01, 8'h04);
        op(6'h20);
        wt(1'b0, 5);
        chk(jpc, 16'h0010);
        chk({15'h0000, gie}, 16'h0000);
        chk({mem.m[8'h21], mem.m[8'h20]}, 16'h1234);
        rreg(8'h04, 8'h22);
        op(6'h02);
        repeat (7) @(posedge clk);
        rreg(8'h04, 8'h24);
        op(6'h01);
        wt(1'b1, 6);
        chk({af, aa}, 16'ha55a);
        rreg(8'h04, 8'h22);
        wreg(8'h00, 8'hfb);
        rreg(8'h00, 8'h00);
        op(6'h04);
        wt(1'b0, 6);
        chk(jpc, 16'h1234);
        chk({15'h0000, gie}, 16'h0001);
        rreg(8'h04, 8'h20);
        op(6'h08);
        @(negedge clk);
        chk({15'h0000, gie}, 16'h0000);
        // Mid-run reset: registers cleared, held source seen again
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rreg(8'h04, 8'h00);
        rreg(8'h01, 8'h00);
        rreg(8'h05, 8'h00);
        rreg(8'h00, 8'h04);
        wrap_up;
    end
endmodule
`default_nettype wire
